// ===== timer16_pwm_regs.vh
// constants for the 16-bit timer waveform generator: register map, fields, modes, tops
`ifndef TIMER16_PWM_REGS_VH
`define TIMER16_PWM_REGS_VH

// ----------------------------------------
// register map (word index on the plain port)
// ----------------------------------------
`define ADDR_CTRL 3'h0
`define ADDR_COUNT 3'h1
`define ADDR_CMP_A 3'h2
`define ADDR_CMP_B 3'h3
`define ADDR_CAPTOP 3'h4
`define ADDR_FLAGS 3'h5

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 3
`define CTRL_COMA_LSB 4
`define CTRL_COMA_MSB 5
`define CTRL_COMB_LSB 6
`define CTRL_COMB_MSB 7
`define CTRL_ROUTE_A 8
`define CTRL_ROUTE_B 9
`define CTRL_DIR_A 10
`define CTRL_DIR_B 11
`define CTRL_RESET 12'h000

// ----------------------------------------
// flag bits
// ----------------------------------------
`define FLAG_OVF 0
`define FLAG_CMP_A 1
`define FLAG_CMP_B 2
`define FLAG_CAP 3

// ----------------------------------------
// waveform modes and tops
// ----------------------------------------
`define WM_PC8 4'h1
`define WM_PC9 4'h2
`define WM_PC10 4'h3
`define WM_FAST8 4'h5
`define WM_FAST9 4'h6
`define WM_FAST10 4'h7
`define WM_PC_CAP 4'ha
`define WM_PC_CMPA 4'hb
`define WM_FAST_CAP 4'he
`define WM_FAST_CMPA 4'hf
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define BOTTOM 16'h0000
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_NONINV 2'h2
`define COM_INV 2'h3

`endif

// ===== compare_channel.v
// one output compare channel: buffer, active compare value and waveform state
`timescale 1ns/10ps
`default_nettype none
`include "timer16_pwm_regs.vh"

module compare_channel #(
  parameter WIDTH = 16,
  parameter TOGGLE_OK = 0
) (
  input wire sys_clk,
  input wire rst,
  input wire tick,
  input wire buf_wr,
  input wire [WIDTH-1:0] buf_wdata,
  input wire buf_load,
  input wire fast_pwm,
  input wire phase_pwm,
  input wire count_up,
  input wire top_hit,
  input wire [WIDTH-1:0] count_value,
  input wire [WIDTH-1:0] top_value,
  input wire [1:0] out_mode,
  output reg [WIDTH-1:0] buf_value,
  output reg [WIDTH-1:0] active_value,
  output wire match,
  output reg wave_state
);

  reg wave_next;

  assign match = (count_value == active_value);

  // ----------------------------------------
  // waveform action
  // ----------------------------------------
  always @* begin
    wave_next = wave_state;
    if (fast_pwm) begin
      if (top_hit) begin
        if (out_mode == `COM_NONINV) begin
          wave_next = 1'b0;
        end else if (out_mode == `COM_INV) begin
          wave_next = 1'b1;
        end
      end
      // match after top so equal-to-top holds a constant level
      if (match) begin
        if (out_mode == `COM_NONINV) begin
          wave_next = 1'b1;
        end else if (out_mode == `COM_INV) begin
          wave_next = 1'b0;
        end else if (out_mode == `COM_TOGGLE && TOGGLE_OK != 0) begin
          wave_next = ~wave_state;
        end
      end
    end else if (phase_pwm) begin
      if (match && out_mode[1]) begin
        if (active_value == `BOTTOM) begin
          wave_next = out_mode[0];
        end else if (active_value == top_value) begin
          wave_next = ~out_mode[0];
        end else if (count_up) begin
          wave_next = out_mode[0];
        end else begin
          wave_next = ~out_mode[0];
        end
      end
    end else if (match) begin
      case (out_mode)
        `COM_TOGGLE: wave_next = ~wave_state;
        `COM_NONINV: wave_next = 1'b0;
        `COM_INV: wave_next = 1'b1;
        default: wave_next = wave_state;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      buf_value <= {WIDTH{1'b0}};
      active_value <= {WIDTH{1'b0}};
      wave_state <= 1'b0;
    end else begin
      if (buf_wr) begin
        buf_value <= buf_wdata;
      end
      if (buf_load) begin
        active_value <= buf_value;
      end
      if (tick) begin
        wave_state <= wave_next;
      end
    end
  end

endmodule // compare_channel
`default_nettype wire

// ===== timer16_pwm.v
// 16-bit timer counter with fast and phase correct pwm waveform generation
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_pwm_regs.vh"

module timer16_pwm #(
  parameter WIDTH = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire tick,
  input wire [2:0] reg_addr,
  input wire [WIDTH-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [WIDTH-1:0] reg_rdata,
  input wire port_value_a,
  input wire port_value_b,
  output wire pin_out_a,
  output wire pin_oe_n_a,
  output wire pin_out_b,
  output wire pin_oe_n_b,
  output wire wave_out_a,
  output wire wave_out_b,
  output wire overflow_flag,
  output wire compare_a_flag,
  output wire compare_b_flag,
  output wire capture_flag
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [11:0] ctrl_reg;
  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] count_next;
  reg count_up_reg;
  reg count_up_next;
  reg [WIDTH-1:0] capture_top_value_reg;
  reg [3:0] flags_reg;
  reg [3:0] flags_next;
  reg [3:0] flag_set;
  reg [WIDTH-1:0] top_value;
  reg fixed_top;
  reg fast_pwm;
  reg phase_pwm;
  reg buf_load;
  reg [WIDTH-1:0] rdata_next;

  wire [3:0] waveform_mode_sel;
  wire [1:0] chan_a_output_mode;
  wire [1:0] chan_b_output_mode;
  wire [WIDTH-1:0] cmp_wdata;
  wire wr_ctrl;
  wire wr_count;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire wr_captop;
  wire wr_flags;
  wire top_hit;
  wire bottom_hit;
  wire match_a;
  wire match_b;
  wire [WIDTH-1:0] buf_a;
  wire [WIDTH-1:0] buf_b;
  wire [WIDTH-1:0] compare_a_value;
  wire wave_state_a;
  wire wave_state_b;

  assign waveform_mode_sel = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign chan_a_output_mode = ctrl_reg[`CTRL_COMA_MSB:`CTRL_COMA_LSB];
  assign chan_b_output_mode = ctrl_reg[`CTRL_COMB_MSB:`CTRL_COMB_LSB];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
  assign wr_count = reg_wr && (reg_addr == `ADDR_COUNT);
  assign wr_cmp_a = reg_wr && (reg_addr == `ADDR_CMP_A);
  assign wr_cmp_b = reg_wr && (reg_addr == `ADDR_CMP_B);
  assign wr_captop = reg_wr && (reg_addr == `ADDR_CAPTOP);
  assign wr_flags = reg_wr && (reg_addr == `ADDR_FLAGS);

  // ----------------------------------------
  // mode decode and top selection
  // ----------------------------------------
  always @* begin
    fast_pwm = 1'b0;
    phase_pwm = 1'b0;
    fixed_top = 1'b0;
    top_value = {WIDTH{1'b1}};
    case (waveform_mode_sel)
      `WM_FAST8: begin
        fast_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TOP_8BIT;
      end
      `WM_FAST9: begin
        fast_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TOP_9BIT;
      end
      `WM_FAST10: begin
        fast_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TOP_10BIT;
      end
      `WM_FAST_CAP: begin
        fast_pwm = 1'b1;
        top_value = capture_top_value_reg;
      end
      `WM_FAST_CMPA: begin
        fast_pwm = 1'b1;
        top_value = compare_a_value;
      end
      `WM_PC8: begin
        phase_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TOP_8BIT;
      end
      `WM_PC9: begin
        phase_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TOP_9BIT;
      end
      `WM_PC10: begin
        phase_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TOP_10BIT;
      end
      `WM_PC_CAP: begin
        phase_pwm = 1'b1;
        top_value = capture_top_value_reg;
      end
      `WM_PC_CMPA: begin
        phase_pwm = 1'b1;
        top_value = compare_a_value;
      end
      default: begin
        top_value = {WIDTH{1'b1}};
      end
    endcase
  end

  // exact equality only: a top written below the count is missed until wrap
  assign top_hit = (count_reg == top_value);
  assign bottom_hit = (count_reg == `BOTTOM);

  // unused high bits vanish in fixed top modes
  assign cmp_wdata = fixed_top ? (reg_wdata & top_value) : reg_wdata;

  // ----------------------------------------
  // counter sequence
  // ----------------------------------------
  always @* begin
    count_next = count_reg;
    count_up_next = count_up_reg;
    buf_load = 1'b0;
    flag_set = 4'h0;
    if (tick) begin
      if (fast_pwm) begin
        count_up_next = 1'b1;
        if (top_hit) begin
          count_next = `BOTTOM;
          buf_load = 1'b1;
          flag_set[`FLAG_OVF] = 1'b1;
          flag_set[`FLAG_CAP] = (waveform_mode_sel == `WM_FAST_CAP);
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end else if (phase_pwm) begin
        if (count_up_reg) begin
          if (top_hit) begin
            // top was already shown for this tick, so the next step is down
            count_next = count_reg - 16'h0001;
            count_up_next = 1'b0;
            buf_load = 1'b1;
            flag_set[`FLAG_CAP] = (waveform_mode_sel == `WM_PC_CAP);
          end else begin
            count_next = count_reg + 16'h0001;
          end
        end else if (bottom_hit) begin
          count_next = 16'h0001;
          count_up_next = 1'b1;
          flag_set[`FLAG_OVF] = 1'b1;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else begin
        count_up_next = 1'b1;
        count_next = count_reg + 16'h0001;
        flag_set[`FLAG_OVF] = (count_reg == {WIDTH{1'b1}});
      end
      flag_set[`FLAG_CMP_A] = match_a;
      flag_set[`FLAG_CMP_B] = match_b;
    end
    // outside pwm modes the compare registers are transparent
    if (!fast_pwm && !phase_pwm) begin
      buf_load = 1'b1;
    end
    if (wr_count) begin
      count_next = reg_wdata;
    end
  end

  // set beats a software clear in the same cycle
  always @* begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = flags_reg & ~reg_wdata[3:0];
    end
    flags_next = flags_next | flag_set;
  end

  // ----------------------------------------
  // compare channels
  // ----------------------------------------
  compare_channel #(
    .WIDTH(WIDTH),
    .TOGGLE_OK(1)
  ) chan_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .buf_wr(wr_cmp_a),
    .buf_wdata(cmp_wdata),
    .buf_load(buf_load),
    .fast_pwm(fast_pwm),
    .phase_pwm(phase_pwm),
    .count_up(count_up_reg),
    .top_hit(top_hit),
    .count_value(count_reg),
    .top_value(top_value),
    .out_mode(chan_a_output_mode),
    .buf_value(buf_a),
    .active_value(compare_a_value),
    .match(match_a),
    .wave_state(wave_state_a)
  );

  compare_channel #(
    .WIDTH(WIDTH),
    .TOGGLE_OK(0)
  ) chan_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .buf_wr(wr_cmp_b),
    .buf_wdata(cmp_wdata),
    .buf_load(buf_load),
    .fast_pwm(fast_pwm),
    .phase_pwm(phase_pwm),
    .count_up(count_up_reg),
    .top_hit(top_hit),
    .count_value(count_reg),
    .top_value(top_value),
    .out_mode(chan_b_output_mode),
    .buf_value(buf_b),
    .active_value(),
    .match(match_b),
    .wave_state(wave_state_b)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rdata_next = {WIDTH{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: rdata_next = {4'h0, ctrl_reg};
        `ADDR_COUNT: rdata_next = count_reg;
        `ADDR_CMP_A: rdata_next = buf_a;
        `ADDR_CMP_B: rdata_next = buf_b;
        `ADDR_CAPTOP: rdata_next = capture_top_value_reg;
        `ADDR_FLAGS: rdata_next = {12'h000, flags_reg};
        default: rdata_next = {WIDTH{1'b0}};
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
      count_reg <= `BOTTOM;
      count_up_reg <= 1'b1;
      capture_top_value_reg <= {WIDTH{1'b0}};
      flags_reg <= 4'h0;
      reg_rdata <= {WIDTH{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[11:0];
      end
      if (wr_captop) begin
        capture_top_value_reg <= reg_wdata;
      end
      count_reg <= count_next;
      count_up_reg <= count_up_next;
      flags_reg <= flags_next;
      reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  assign pin_out_a = ((chan_a_output_mode != `COM_OFF) && ctrl_reg[`CTRL_ROUTE_A]) ?
    wave_state_a : port_value_a;
  assign pin_out_b = ((chan_b_output_mode != `COM_OFF) && ctrl_reg[`CTRL_ROUTE_B]) ?
    wave_state_b : port_value_b;
  assign pin_oe_n_a = ~ctrl_reg[`CTRL_DIR_A];
  assign pin_oe_n_b = ~ctrl_reg[`CTRL_DIR_B];

  assign wave_out_a = wave_state_a;
  assign wave_out_b = wave_state_b;
  assign overflow_flag = flags_reg[`FLAG_OVF];
  assign compare_a_flag = flags_reg[`FLAG_CMP_A];
  assign compare_b_flag = flags_reg[`FLAG_CMP_B];
  assign capture_flag = flags_reg[`FLAG_CAP];

endmodule // timer16_pwm
`default_nettype wire

// ===== timer16_pwm_chk.sv
// port level checker for the timer16_pwm waveform generator
`timescale 1ns/10ps
`default_nettype none
module timer16_pwm_chk #(
  parameter WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [2:0] reg_addr,
  input wire logic [WIDTH-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [WIDTH-1:0] reg_rdata,
  input wire logic port_value_a,
  input wire logic port_value_b,
  input wire logic pin_out_a,
  input wire logic pin_oe_n_a,
  input wire logic pin_out_b,
  input wire logic pin_oe_n_b,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic overflow_flag,
  input wire logic compare_a_flag,
  input wire logic compare_b_flag,
  input wire logic capture_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // control shadow
  // ----------------------------------------
  logic [11:0] ctl_reg;
  always @(posedge sys_clk) begin
    if (rst)
      ctl_reg <= 12'h000;
    else if (reg_wr && reg_addr == 3'h0)
      ctl_reg <= reg_wdata[11:0];
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_oe_dir_a: assert property (pin_oe_n_a == !ctl_reg[10])
    else $error("pin a drive enable wrong");
  a_oe_dir_b: assert property (pin_oe_n_b == !ctl_reg[11])
    else $error("pin b drive enable wrong");
  a_pin_src_a: assert property (pin_out_a == ((ctl_reg[5:4] != 2'h0 && ctl_reg[8]) ? wave_out_a : port_value_a))
    else $error("pin a source wrong");
  a_pin_src_b: assert property (pin_out_b == ((ctl_reg[7:6] != 2'h0 && ctl_reg[9]) ? wave_out_b : port_value_b))
    else $error("pin b source wrong");
  a_flag_on_tick: assert property ($rose(overflow_flag) || $rose(capture_flag) || $rose(compare_a_flag)
    || $rose(compare_b_flag) |-> $past(tick))
    else $error("flag set without timer tick");
  a_wave_on_tick: assert property (!$stable(wave_out_a) || !$stable(wave_out_b) |-> $past(tick))
    else $error("wave changed without timer tick");
  a_mode_off_hold: assert property (ctl_reg[5:4] == 2'h0 |=> $stable(wave_out_a))
    else $error("wave a moved with output mode off");
  a_sticky_ovf: assert property ($fell(overflow_flag) |-> $past(reg_wr && reg_addr == 3'h5 && reg_wdata[0]))
    else $error("overflow flag dropped without clear");
  a_fast_cap_top: assert property ($past(ctl_reg[3:0]) == 4'he && $rose(overflow_flag) |-> capture_flag)
    else $error("capture flag missing at top");
  a_fast_cmpa_top: assert property ($past(ctl_reg[3:0]) == 4'hf && $rose(overflow_flag) |-> compare_a_flag)
    else $error("compare a flag missing at top");
  a_phase_split: assert property ($past(ctl_reg[3:0]) == 4'ha && $rose(capture_flag) |-> !$rose(overflow_flag))
    else $error("overflow at top in phase mode");
endmodule // timer16_pwm_chk

bind timer16_pwm timer16_pwm_chk #(.WIDTH(WIDTH)) chk_u (.sys_clk(sys_clk), .rst(rst), .tick(tick),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port_value_a(port_value_a), .port_value_b(port_value_b), .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a),
  .pin_out_b(pin_out_b), .pin_oe_n_b(pin_oe_n_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
  .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag),
  .capture_flag(capture_flag));
`default_nettype wire

// ===== pin_load.sv
// load on one compare pin: resolves the wire level
`timescale 1ns/10ps
`default_nettype none
module pin_load (
  input wire logic sys_clk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic level
);
  logic last_reg = 1'b0;
  always @(posedge sys_clk)
    last_reg <= level;
  // no pull on the wire: a released pin flips each cycle so a stale level never passes
  assign level = pin_oe_n ? ~last_reg : pin_out;
endmodule // pin_load
`default_nettype wire

// ===== tb_timer16_pwm.sv
// self-checking testbench for timer16_pwm
`timescale 1ns/10ps
`default_nettype none
module tb_timer16_pwm;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tick = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic port_value_a = 1'b0;
  logic port_value_b = 1'b1;
  wire [15:0] reg_rdata;
  wire pin_out_a, pin_oe_n_a, pin_out_b, pin_oe_n_b, wave_out_a, wave_out_b, level_a;
  wire overflow_flag, compare_a_flag, compare_b_flag, capture_flag;
  int fails = 0;
  int tests_run = 0;
  always #2 sys_clk = ~sys_clk;
  timer16_pwm #(.WIDTH(16)) dut_u (.sys_clk(sys_clk), .rst(rst), .tick(tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_value_a(port_value_a), .port_value_b(port_value_b), .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a),
    .pin_out_b(pin_out_b), .pin_oe_n_b(pin_oe_n_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag),
    .capture_flag(capture_flag));
  pin_load load_u (.sys_clk(sys_clk), .pin_out(pin_out_a), .pin_oe_n(pin_oe_n_a), .level(level_a));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1;
    chk(reg_rdata, exp);
  endtask
  // tick held for exactly n sampling edges; counter frozen otherwise
  task automatic ticks(input int n);
    @(posedge sys_clk);
    tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    tick <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle();
    do_reset();
    rdchk(3'h0, 16'h0000);
    rdchk(3'h1, 16'h0000);
    rdchk(3'h5, 16'h0000);
    wr(3'h7, 16'h1234);
    rdchk(3'h7, 16'h0000);
    chk(pin_oe_n_a, 1'b1);
    wr(3'h0, 16'h0505);
    port_value_a <= 1'b1;
    ticks(20);
    chk(pin_out_a, 1'b1);
    chk(pin_oe_n_a, 1'b0);
    chk(wave_out_a, 1'b0);
    $display("test idle done");
  endtask
  // fast modes 5..7 wrap at top, phase modes 1..3 turn back at top
  task automatic t_fixed();
    logic [15:0] top;
    for (int i = 0; i < 6; i++) begin
      top = 16'((256 << (i % 3)) - 1);
      do_reset();
      wr(3'h0, 16'((i < 3) ? 5 + i : i - 2));
      wr(3'h2, 16'hffff);
      rdchk(3'h2, top);
      wr(3'h1, top - 16'h0001);
      ticks(1);
      rdchk(3'h1, top);
      ticks(1);
      rdchk(3'h1, (i < 3) ? 16'h0000 : top - 16'h0001);
      chk(overflow_flag, (i < 3) ? 1'b1 : 1'b0);
      repeat (6) @(posedge sys_clk);
      rdchk(3'h1, (i < 3) ? 16'h0000 : top - 16'h0001);
    end
    $display("test fixed done");
  endtask
  task automatic t_fast_cap();
    logic [15:0] c;
    logic ea;
    do_reset();
    wr(3'h4, 16'h0003);
    wr(3'h2, 16'h0001);
    wr(3'h3, 16'h0003);
    wr(3'h0, 16'h05ee);
    ticks(4);
    c = 16'h0000;
    ea = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ea = (c == 16'h0001) ? 1'b1 : (c == 16'h0003) ? 1'b0 : ea;
      c = (c == 16'h0003) ? 16'h0000 : c + 16'h0001;
      ticks(1);
      chk(wave_out_a, ea);
      chk(level_a, ea);
      if (i > 3) chk(wave_out_b, 1'b0);
    end
    wr(3'h1, 16'h0003);
    wr(3'h4, 16'h0002);
    ticks(1);
    rdchk(3'h1, 16'h0004);
    $display("test fast capture done");
  endtask
  task automatic t_buffer();
    logic w;
    do_reset();
    // mode first: outside pwm modes the compare write would go straight to active
    wr(3'h0, 16'h001f);
    wr(3'h2, 16'h0005);
    ticks(1);
    rdchk(3'h1, 16'h0000);
    chk(compare_a_flag, 1'b1);
    wr(3'h2, 16'h0003);
    rdchk(3'h2, 16'h0003);
    ticks(4);
    rdchk(3'h1, 16'h0004);
    w = wave_out_a;
    ticks(2);
    rdchk(3'h1, 16'h0000);
    chk(wave_out_a, !w);
    ticks(4);
    rdchk(3'h1, 16'h0000);
    chk(wave_out_a, w);
    $display("test buffer done");
  endtask
  task automatic t_phase();
    logic [15:0] c;
    logic up;
    logic ea;
    do_reset();
    wr(3'h4, 16'h0004);
    wr(3'h2, 16'h0002);
    wr(3'h0, 16'h00ea);
    ticks(5);
    c = 16'h0003;
    up = 1'b0;
    ea = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (c == 16'h0002)
        ea = !up;
      if (c == 16'h0004)
        up = 1'b0;
      if (c == 16'h0000)
        up = 1'b1;
      c = up ? c + 16'h0001 : c - 16'h0001;
      ticks(1);
      rdchk(3'h1, c);
      if (i > 1) chk(wave_out_a, ea);
      chk(wave_out_b, 1'b1);
    end
    chk(overflow_flag, 1'b1);
    chk(capture_flag, 1'b1);
    rdchk(3'h5, 16'h000f);
    wr(3'h5, 16'h000f);
    rdchk(3'h5, 16'h0000);
    // compare a as top: count is 1 and rising, top is the loaded compare 2
    wr(3'h0, 16'h000b);
    ticks(2);
    rdchk(3'h1, 16'h0001);
    chk(compare_a_flag, 1'b1);
    chk(overflow_flag, 1'b0);
    $display("test phase done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_idle();
    t_fixed();
    t_fast_cap();
    t_buffer();
    t_phase();
    results();
  end
  initial begin
    #200000;
    fails++;
    results();
  end
endmodule // tb_timer16_pwm
`default_nettype wire
